// ===== hw/pm_preload_pkg.sv
// Constants, types and field layout for the power-management field preload.
// What this block does
// [RULE1] Image word 50h bit 0 loads port 0 offset 44h bit 3.
// [RULE2] Image word 52h bit 0 loads port 1 offset 44h bit 3.
// [RULE3] Image word 54h bit 0 loads port 2 offset 44h bit 3.
// [RULE4] Keep-state word bits 3:1 load aux current at offset 40h bits 24:22.
// [RULE5] Offset 40h bit 25 reads as 1: D1 state supported.
// [RULE6] Offset 40h bit 26 reads as 1: D2 state supported.
// [RULE7] Keep-state word bits 7:6 load wake flags at offset 40h bits 29:28.
// [RULE8] Image word 51h bits 15:8 load port 0 data byte, offset 44h 31:24.
// [RULE9] Image word 53h bits 15:8 load port 1 data byte, offset 44h 31:24.
// [RULE10] Port 2 preload word bit 13 loads compliance control, offset 78h bit 11.
// [RULE11] Port 2 preload word bits 15:14 load count select, offset 8Ch bits 9:8.
// [RULE12] Copies finish before config space opens; uncovered fields keep defaults.
`default_nettype none
package pm_preload_pkg;
    localparam int NUM_PORTS = 3;
    localparam int IMG_AW = 8;
    localparam int IMG_DW = 16;
    localparam int CFG_AW = 12;
    localparam int CFG_DW = 32;

    // Image word addresses
    localparam logic [IMG_AW-1:0] WORD_KEEP_P0 = 8'h50;
    localparam logic [IMG_AW-1:0] WORD_DATA_P0 = 8'h51;
    localparam logic [IMG_AW-1:0] WORD_KEEP_P1 = 8'h52;
    localparam logic [IMG_AW-1:0] WORD_DATA_P1 = 8'h53;
    localparam logic [IMG_AW-1:0] WORD_KEEP_P2 = 8'h54;
    localparam logic [IMG_AW-1:0] WORD_PHY_P2 = 8'h44;

    // Configuration register offsets
    localparam logic [CFG_AW-1:0] OFS_PM_CAP = 12'h040;
    localparam logic [CFG_AW-1:0] OFS_PM_CTRL_DATA = 12'h044;
    localparam logic [CFG_AW-1:0] OFS_PHY_LINK = 12'h078;
    localparam logic [CFG_AW-1:0] OFS_PHY_DCHG = 12'h08C;

    // Source bit positions inside image words
    localparam int SRC_KEEP = 0;
    localparam int SRC_AUX_LO = 1;
    localparam int SRC_WAKE_LO = 6;
    localparam int SRC_DATA_LO = 8;
    localparam int SRC_COMPL = 13;
    localparam int SRC_DCC_LO = 14;

    // Destination bit positions inside configuration registers
    localparam int DST_KEEP = 3;
    localparam int DST_AUX_LO = 22;
    localparam int DST_D1 = 25;
    localparam int DST_D2 = 26;
    localparam int DST_WAKE_LO = 28;
    localparam int DST_DATA_LO = 24;
    localparam int DST_COMPL = 11;
    localparam int DST_DCC_LO = 8;

    // Field widths
    localparam int AUX_W = 3;
    localparam int WAKE_W = 2;
    localparam int DATA_W = 8;
    localparam int DCC_W = 2;

    typedef enum logic [1:0] {
        UPD_NONE,
        UPD_KEEP,
        UPD_DATA,
        UPD_PHY
    } upd_kind_e;

    typedef enum logic {
        ST_LOAD,
        ST_OPEN
    } load_state_e;
endpackage

`default_nettype wire

// ===== hw/preload_if.sv
// Decoded image-word updates passed from the decoder to the register store.
`timescale 1ns/1ps
`default_nettype none
interface preload_if;
    import pm_preload_pkg::*;
    upd_kind_e kind;
    logic [1:0] port;
    logic [IMG_DW-1:0] data;
    modport dec (output kind, output port, output data);
    modport app (input kind, input port, input data);
endinterface
`default_nettype wire

// ===== hw/preload_word_decode.sv
// Classifies one image word by address into an update kind and target port.
`timescale 1ns/1ps
`default_nettype none
module preload_word_decode
    import pm_preload_pkg::*;
(
    // Image word
    input wire logic valid,
    input wire logic [IMG_AW-1:0] addr,
    input wire logic [IMG_DW-1:0] data,
    // Decoded update
    preload_if.dec upd
);
    // Address to kind; words outside this slice of the image are ignored
    function automatic upd_kind_e word_kind(input logic [IMG_AW-1:0] a);
        case (a)
            WORD_KEEP_P0, WORD_KEEP_P1, WORD_KEEP_P2: word_kind = UPD_KEEP;
            WORD_DATA_P0, WORD_DATA_P1: word_kind = UPD_DATA;
            WORD_PHY_P2: word_kind = UPD_PHY;
            default: word_kind = UPD_NONE;
        endcase
    endfunction

    // Address to port index
    function automatic logic [1:0] word_port(input logic [IMG_AW-1:0] a);
        case (a)
            WORD_KEEP_P1, WORD_DATA_P1: word_port = 2'h1;
            WORD_KEEP_P2, WORD_PHY_P2: word_port = 2'h2;
            default: word_port = 2'h0;
        endcase
    endfunction

    // Pure decode, no state
    always_comb begin
        upd.kind = valid ? word_kind(addr) : UPD_NONE;
        upd.port = word_port(addr);
        upd.data = data;
    end
endmodule // preload_word_decode
`default_nettype wire

// ===== hw/pm_field_preload_map.sv
// Preloads per-port power-management fields and port 2 PHY fields, then serves config reads.
`timescale 1ns/1ps
`default_nettype none
module pm_field_preload_map
    import pm_preload_pkg::*;
#(
    parameter logic DEF_KEEP = 1'b0,
    parameter logic [AUX_W-1:0] DEF_AUX = 3'h0,
    parameter logic [WAKE_W-1:0] DEF_WAKE = 2'h0,
    parameter logic [DATA_W-1:0] DEF_DATA = 8'h00,
    parameter logic DEF_COMPL = 1'b0,
    parameter logic [DCC_W-1:0] DEF_DCC = 2'h0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Configuration image words
    input wire logic img_valid,
    input wire logic [IMG_AW-1:0] img_addr,
    input wire logic [IMG_DW-1:0] img_data,
    input wire logic img_done,
    // Configuration space access
    output logic cfg_open,
    input wire logic cfg_rd_en,
    input wire logic [1:0] cfg_port,
    input wire logic [CFG_AW-1:0] cfg_offset,
    output logic cfg_rd_valid,
    output logic [CFG_DW-1:0] cfg_rdata
);
    load_state_e state_q;
    logic take_word;
    logic [NUM_PORTS-1:0] keep_q;
    logic [AUX_W-1:0] aux_q [NUM_PORTS];
    logic [WAKE_W-1:0] wake_q [NUM_PORTS];
    logic [DATA_W-1:0] data_q [NUM_PORTS];
    logic compl_q;
    logic [DCC_W-1:0] dcc_q;
    logic [CFG_DW-1:0] rd_d;
    logic [1:0] rp;

    preload_if upd ();

    preload_word_decode u_decode (
        .valid(take_word),
        .addr(img_addr),
        .data(img_data),
        .upd(upd)
    );

    // Words only count while loading; late words cannot disturb open space
    assign take_word = img_valid && (state_q == ST_LOAD);
    assign cfg_open = (state_q == ST_OPEN);

    // Load phase ends on the image's done strobe, never earlier
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q <= ST_LOAD;
        end else begin
            case (state_q)
                ST_LOAD: if (img_done) state_q <= ST_OPEN; // RULE12
                ST_OPEN: state_q <= ST_OPEN;
                default: state_q <= ST_LOAD;
            endcase
        end
    end

    // Keep-state word fields, one slot per port
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                keep_q[i] <= DEF_KEEP; // RULE12
                aux_q[i] <= DEF_AUX;
                wake_q[i] <= DEF_WAKE;
            end
        end else if (upd.kind == UPD_KEEP) begin
            keep_q[upd.port] <= upd.data[SRC_KEEP]; // RULE1 RULE2 RULE3
            aux_q[upd.port] <= upd.data[SRC_AUX_LO +: AUX_W]; // RULE4
            wake_q[upd.port] <= upd.data[SRC_WAKE_LO +: WAKE_W]; // RULE7
        end
    end

    // Data byte; port 2 has no word in this slice and keeps its default
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_PORTS; i++) begin
                data_q[i] <= DEF_DATA;
            end
        end else if (upd.kind == UPD_DATA) begin
            data_q[upd.port] <= upd.data[SRC_DATA_LO +: DATA_W]; // RULE8 RULE9
        end
    end

    // Port 2 PHY link fields
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            compl_q <= DEF_COMPL;
            dcc_q <= DEF_DCC;
        end else if (upd.kind == UPD_PHY) begin
            compl_q <= upd.data[SRC_COMPL]; // RULE10
            dcc_q <= upd.data[SRC_DCC_LO +: DCC_W]; // RULE11
        end
    end

    // Read mux; unmapped offsets and ports read zero
    always_comb begin
        rd_d = '0;
        rp = (cfg_port < 2'(NUM_PORTS)) ? cfg_port : 2'h0;
        if (cfg_port < 2'(NUM_PORTS)) begin
            case (cfg_offset)
                OFS_PM_CAP: begin
                    rd_d[DST_AUX_LO +: AUX_W] = aux_q[rp];
                    rd_d[DST_D1] = 1'b1; // RULE5
                    rd_d[DST_D2] = 1'b1; // RULE6
                    rd_d[DST_WAKE_LO +: WAKE_W] = wake_q[rp];
                end
                OFS_PM_CTRL_DATA: begin
                    rd_d[DST_KEEP] = keep_q[rp];
                    rd_d[DST_DATA_LO +: DATA_W] = data_q[rp];
                end
                OFS_PHY_LINK: rd_d[DST_COMPL] = (rp == 2'h2) ? compl_q : DEF_COMPL;
                OFS_PHY_DCHG: rd_d[DST_DCC_LO +: DCC_W] = (rp == 2'h2) ? dcc_q : DEF_DCC;
                default: rd_d = '0;
            endcase
        end
    end

    // Registered read answer; reads before opening get no answer at all
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_rd_valid <= 1'b0;
            cfg_rdata <= '0;
        end else begin
            cfg_rd_valid <= cfg_rd_en && cfg_open; // RULE12
            if (cfg_rd_en && cfg_open) cfg_rdata <= rd_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    keep_port0_a: assert property (take_word && img_addr == WORD_KEEP_P0 |=> // RULE1
        keep_q[0] == $past(img_data[SRC_KEEP])) else $error("port 0 keep bit wrong");
    keep_port1_a: assert property (take_word && img_addr == WORD_KEEP_P1 |=> // RULE2
        keep_q[1] == $past(img_data[SRC_KEEP])) else $error("port 1 keep bit wrong");
    keep_port2_a: assert property (take_word && img_addr == WORD_KEEP_P2 |=> // RULE3
        keep_q[2] == $past(img_data[SRC_KEEP])) else $error("port 2 keep bit wrong");
    aux_current_a: assert property (take_word && img_addr == WORD_KEEP_P1 |=> // RULE4
        aux_q[1] == $past(img_data[3:1])) else $error("aux current wrong");
    d1_support_a: assert property (cfg_rd_en && cfg_open && cfg_offset == OFS_PM_CAP // RULE5
        && cfg_port < 2'h3 |=> cfg_rdata[25]) else $error("D1 bit not one");
    d2_support_a: assert property (cfg_rd_en && cfg_open && cfg_offset == OFS_PM_CAP // RULE6
        && cfg_port < 2'h3 |=> cfg_rdata[26]) else $error("D2 bit not one");
    wake_flags_a: assert property (take_word && img_addr == WORD_KEEP_P0 |=> // RULE7
        wake_q[0] == $past(img_data[7:6])) else $error("wake flags wrong");
    data_port0_a: assert property (take_word && img_addr == WORD_DATA_P0 |=> // RULE8
        data_q[0] == $past(img_data[15:8])) else $error("port 0 data wrong");
    data_port1_a: assert property (take_word && img_addr == WORD_DATA_P1 |=> // RULE9
        data_q[1] == $past(img_data[15:8])) else $error("port 1 data wrong");
    compliance_a: assert property (take_word && img_addr == WORD_PHY_P2 |=> // RULE10
        compl_q == $past(img_data[13])) else $error("compliance wrong");
    count_select_a: assert property (take_word && img_addr == WORD_PHY_P2 |=> // RULE11
        dcc_q == $past(img_data[15:14])) else $error("count select wrong");
    open_after_load_a: assert property ($rose(cfg_open) |-> $past(img_done) // RULE12
        && !$past(cfg_rd_valid)) else $error("opened without done");
    closed_no_read_a: assert property (!cfg_open && cfg_rd_en |=> !cfg_rd_valid) // RULE12
        else $error("read answered before open");

    // Keep-state fields of the ports that the checks above leave out
    aux_port0_a: assert property (take_word && img_addr == WORD_KEEP_P0 |=> // RULE4
        aux_q[0] == $past(img_data[3:1]))
        else $error("port 0 aux current wrong");
    aux_port2_a: assert property (take_word && img_addr == WORD_KEEP_P2 |=> // RULE4
        aux_q[2] == $past(img_data[3:1]))
        else $error("port 2 aux current wrong");
    wake_port1_a: assert property (take_word && img_addr == WORD_KEEP_P1 |=> // RULE7
        wake_q[1] == $past(img_data[7:6]))
        else $error("port 1 wake flags wrong");
    wake_port2_a: assert property (take_word && img_addr == WORD_KEEP_P2 |=> // RULE7
        wake_q[2] == $past(img_data[7:6]))
        else $error("port 2 wake flags wrong");

    // Read answers carry the stored fields at their host-visible positions
    aux_read_a: assert property (cfg_rd_en && cfg_open && cfg_offset == OFS_PM_CAP // RULE4
        && cfg_port < 2'(NUM_PORTS) |=> cfg_rdata[24:22] == $past(aux_q[rp]))
        else $error("aux current read wrong");
    wake_read_a: assert property (cfg_rd_en && cfg_open && cfg_offset == OFS_PM_CAP // RULE7
        && cfg_port < 2'(NUM_PORTS) |=> cfg_rdata[29:28] == $past(wake_q[rp]))
        else $error("wake flags read wrong");
    keep_read_a: assert property (cfg_rd_en && cfg_open // RULE1 RULE2 RULE3
        && cfg_offset == OFS_PM_CTRL_DATA && cfg_port < 2'(NUM_PORTS) |=> cfg_rdata[3] == $past(keep_q[rp]))
        else $error("keep bit read wrong");
    data_read_a: assert property (cfg_rd_en && cfg_open // RULE8 RULE9
        && cfg_offset == OFS_PM_CTRL_DATA && cfg_port < 2'(NUM_PORTS) |=> cfg_rdata[31:24] == $past(data_q[rp]))
        else $error("data byte read wrong");
    compl_read_a: assert property (cfg_rd_en && cfg_open && cfg_offset == OFS_PHY_LINK // RULE10
        && cfg_port == 2'h2 |=> cfg_rdata[11] == $past(compl_q))
        else $error("compliance read wrong");
    dcc_read_a: assert property (cfg_rd_en && cfg_open && cfg_offset == OFS_PHY_DCHG // RULE11
        && cfg_port == 2'h2 |=> cfg_rdata[9:8] == $past(dcc_q))
        else $error("count select read wrong");
    compl_other_a: assert property (cfg_rd_en && cfg_open && cfg_offset == OFS_PHY_LINK // RULE10
        && cfg_port < 2'h2 |=> cfg_rdata[11] == DEF_COMPL)
        else $error("compliance leaked to port 0 or 1");
    dcc_other_a: assert property (cfg_rd_en && cfg_open && cfg_offset == OFS_PHY_DCHG // RULE11
        && cfg_port < 2'h2 |=> cfg_rdata[9:8] == DEF_DCC)
        else $error("count select leaked to port 0 or 1");

    // Refusals: closed reads and late words leave no trace, space never closes, missing ports read zero
    closed_hold_a: assert property (!cfg_open && cfg_rd_en |=> // RULE12
        $stable(cfg_rdata))
        else $error("read data moved before open");
    late_word_a: assert property (cfg_open && img_valid |=> // RULE12
        $stable(keep_q) && $stable(compl_q) && $stable(dcc_q))
        else $error("word taken after open");
    stays_open_a: assert property (cfg_open |=> // RULE12
        cfg_open)
        else $error("config space closed again");
    no_port_a: assert property (cfg_rd_en && cfg_open && cfg_port == 2'h3 |=> // RULE12
        cfg_rdata == '0)
        else $error("missing port read not zero");
endmodule // pm_field_preload_map
`default_nettype wire

// ===== dv/img_store_model.sv
// Image store model that plays configuration words into the preload port.
`timescale 1ns/1ps
`default_nettype none
module img_store_model
    import pm_preload_pkg::*;
(
    // Clock
    input wire logic clock,
    // Image words
    output logic img_valid,
    output logic [IMG_AW-1:0] img_addr,
    output logic [IMG_DW-1:0] img_data,
    output logic img_done
);
    // Idle at time zero
    initial begin
        img_valid = 1'b0;
        img_done = 1'b0;
        img_addr = 8'h00;
        img_data = 16'h0000;
    end
    // One word per call; after release the bus shows inverted junk, not stale data
    task automatic put(input logic [IMG_AW-1:0] a, input logic [IMG_DW-1:0] d, input logic last);
        @(posedge clock) #1;
        img_valid = 1'b1;
        img_addr = a;
        img_data = d;
        img_done = last;
        @(posedge clock) #1;
        img_valid = 1'b0;
        img_done = 1'b0;
        img_addr = ~a;
        img_data = ~d;
    endtask
endmodule // img_store_model
`default_nettype wire

// ===== dv/test_pm_field_preload_map.sv
// Self-checking bench for the power-management field preload.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module test_pm_field_preload_map;
    import pm_preload_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic img_valid;
    logic img_done;
    logic [IMG_AW-1:0] img_addr;
    logic [IMG_DW-1:0] img_data;
    logic cfg_open;
    logic cfg_rd_en = 1'b0;
    logic [1:0] cfg_port = 2'h0;
    logic [CFG_AW-1:0] cfg_offset = 12'h000;
    logic cfg_rd_valid;
    logic [CFG_DW-1:0] cfg_rdata;
    int mismatches = 0;
    int total_checks = 0;
    // Image table; the odd word at 7Fh must be ignored
    logic [IMG_AW-1:0] wa [7] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h54, 8'h44, 8'h7F};
    logic [IMG_DW-1:0] wd [7] = '{16'h00C7, 16'hA5FF, 16'h0049, 16'h3C00, 16'h00BE,
        16'hA000, 16'hFFFF};
    logic [IMG_DW-1:0] kw [3] = '{16'h00C7, 16'h0049, 16'h00BE};
    logic [7:0] db [3] = '{8'hA5, 8'h3C, 8'h00};

    always #50 clock = ~clock;

    pm_field_preload_map uut (.clock(clock), .rst(rst), .img_valid(img_valid),
        .img_addr(img_addr), .img_data(img_data), .img_done(img_done), .cfg_open(cfg_open),
        .cfg_rd_en(cfg_rd_en), .cfg_port(cfg_port), .cfg_offset(cfg_offset),
        .cfg_rd_valid(cfg_rd_valid), .cfg_rdata(cfg_rdata));
    img_store_model img (.clock(clock), .img_valid(img_valid), .img_addr(img_addr),
        .img_data(img_data), .img_done(img_done));

    // Expected capability word from a keep-state word
    function automatic logic [31:0] cap(input logic [15:0] w);
        cap = 32'h00000000;
        cap[29:28] = w[7:6];
        cap[26:25] = 2'h3;
        cap[24:22] = w[3:1];
    endfunction
    // Expected control/data word
    function automatic logic [31:0] ctl(input logic [15:0] k, input logic [7:0] b);
        ctl = {b, 20'h00000, k[0], 3'h0};
    endfunction
    // One host read; v says whether an answer is due
    task automatic rd(input logic [1:0] p, input logic [11:0] o, input logic v,
        input logic [31:0] e);
        @(posedge clock) #1;
        cfg_rd_en = 1'b1;
        cfg_port = p;
        cfg_offset = o;
        @(posedge clock) #1;
        cfg_rd_en = 1'b0;
        `CHK("rd_valid", v, cfg_rd_valid)
        if (v) `CHK("rdata", e, cfg_rdata)
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog at 2000 cycles, far beyond the roughly fifty cycles the tests need
    initial begin
        #200000;
        mismatches++;
        finish_test;
    end

    initial begin
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        // Load phase: closed, reads refused, overwritten word, unknown word
        `CHK("open_in_load", 1'b0, cfg_open)
        rd(2'h0, OFS_PM_CAP, 1'b0, 32'h00000000);
        `CHK("rdata_closed", 32'h00000000, cfg_rdata)
        img.put(WORD_KEEP_P0, 16'hFFFF, 1'b0);
        foreach (wa[i]) img.put(wa[i], wd[i], i == 6);
        @(posedge clock) #1;
        `CHK("open_after_done", 1'b1, cfg_open)
        img.put(WORD_KEEP_P0, 16'h0000, 1'b0);
        $display("test load done");
        // Read back every mapped field of every port
        for (int p = 0; p < 3; p++) begin
            rd(p[1:0], OFS_PM_CAP, 1'b1, cap(kw[p]));
            rd(p[1:0], OFS_PM_CTRL_DATA, 1'b1, ctl(kw[p], db[p]));
            rd(p[1:0], OFS_PHY_LINK, 1'b1, (p == 2) ? 32'h00000800 : 32'h00000000);
            rd(p[1:0], OFS_PHY_DCHG, 1'b1, (p == 2) ? 32'h00000200 : 32'h00000000);
        end
        rd(2'h0, 12'h048, 1'b1, 32'h00000000);
        rd(2'h3, OFS_PM_CAP, 1'b1, 32'h00000000);
        $display("test readback done");
        finish_test;
    end
endmodule // test_pm_field_preload_map
`default_nettype wire
